// File: iomd_decoder.sv
// I/O register bank and address decoder of the peripheral space
`timescale 1ns/1ps

// Contract
// - Thirteen-bit address spans eight kilobyte space
// - Registers at bytes 0 through 1F
// - Watchdog service location decoded at 1FF0
// - Registers reached by ordinary memory cycles
// - Port A data bits 7,6 read zero
// - Port A direction upper two bits zero
// - Port B direction holds eight bits
// - Port A/C pulldown inhibit is write-only
// - Port B pulldown inhibit is write-only
// - Tick timer flags, enables, rate, clear strobes
// - External interrupt enable, mode, flag, clear
// - Capture value read-only, high at 14
// - Compare value read/write, high at 16
// - Free count read-only, high at 18
// - Alternate count view at 1A/1B
// - Analog select register eight read/write bits
// - Port C only on larger package
module iomd_decoder #(
    parameter bit HAS_PORT_C = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Processor bus
    input wire iomd_pkg::iomd_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // Peripheral state in
    input wire logic [7:0] pa_pin_in,
    input wire logic [7:0] pb_pin_in,
    input wire logic [7:0] pc_pin_in,
    input wire logic tick_ovf_event,
    input wire logic tick_per_event,
    input wire logic ext_irq_event,
    input wire logic [7:0] tick_count,
    input wire logic [7:0] ser_ctrl_in,
    input wire logic [7:0] ser_flags_in,
    input wire logic [7:0] ser_data_in,
    input wire logic [7:0] cap_ctrl_in,
    input wire logic [7:0] cap_flags_in,
    input wire logic [15:0] capture_value,
    input wire logic [15:0] free_count,
    input wire logic [7:0] ana_ctrl_in,
    input wire logic [7:0] ana_flags_in,
    // Controls and strobes out
    output iomd_pkg::iomd_ctrl_t ctrl,
    output logic periph_wr,
    output logic [4:0] periph_wr_off,
    output logic [7:0] periph_wr_data,
    output logic watchdog_service
);
    // Bus timing in short: a request is taken at the rising edge where
    // req.valid is high. A write lands at that same edge, and a read is
    // answered one cycle later through the registered rdata and rvalid.
    // There are no wait states, so the core may issue a request on every
    // clock. Addresses outside the I/O block and the watchdog slot belong
    // to RAM and ROM; this block answers zero for them, so the read paths
    // of the memories must be merged outside with an OR or a mux.
    // Peripherals that own their registers get a registered copy of every
    // write in the block and decode their own slots from it.
    // Flags that hardware sets and software clears are sticky here.
    logic in_io;
    logic hit_wd;
    logic tick_wr;
    logic ext_wr;
    logic tick_ovf_clr;
    logic tick_per_clr;
    logic ext_clr;
    logic wr_io;
    logic [4:0] off;
    logic [7:0] next_rdata;
    logic [7:0] pc_mask;

    // Address decode over the full 13-bit space
    assign in_io = req.valid && (req.addr < iomd_pkg::IO_LIMIT);
    assign hit_wd = req.valid && (req.addr == iomd_pkg::WATCHDOG_ADDR);
    assign wr_io = in_io && req.write;
    assign off = req.addr[4:0];
    // Port C bits vanish on the small package
    assign pc_mask = HAS_PORT_C ? 8'hff : 8'h00;

    // Clear strobes live for the write cycle only and are never stored
    assign tick_wr = wr_io && (off == iomd_pkg::OFF_TICK_CS);
    assign ext_wr = wr_io && (off == iomd_pkg::OFF_EXT_CS);
    assign tick_ovf_clr = tick_wr && req.wdata[iomd_pkg::TICK_OVF_CLR_BIT];
    assign tick_per_clr = tick_wr && req.wdata[iomd_pkg::TICK_PER_CLR_BIT];
    assign ext_clr = ext_wr && req.wdata[iomd_pkg::EXT_CLR_BIT];

    // Slot map of the I/O block, offset and what a read returns:
    //   00 port A pins, bits 7:6 zero
    //   01 port B pins
    //   02 port C pins, zero without port C
    //   03 analog input select
    //   04 port A direction, bits 7:6 zero
    //   05 port B direction
    //   06 port C direction
    //   07 unused, zero
    //   08 tick timer control and flags, strobes read zero
    //   09 tick timer count view
    //   0a serial control view
    //   0b serial flags view
    //   0c serial data view
    //   0d external interrupt control and flag
    //   0e unused, zero
    //   0f unused, zero
    //   10 port A/C pulldown inhibit, write-only, zero
    //   11 port B pulldown inhibit, write-only, zero
    //   12 capture timer control view
    //   13 capture timer flags view
    //   14 capture value high byte
    //   15 capture value low byte
    //   16 compare value high byte
    //   17 compare value low byte
    //   18 free count high byte
    //   19 free count low byte
    //   1a free count high byte, second view
    //   1b free count low byte, second view
    //   1c unused, zero
    //   1d analog control view
    //   1e analog flags view
    //   1f reserved, zero
    // Outside the block only 1ff0 is decoded, as a write-only pulse.
    // The two byte halves of a 16-bit view are not latched together, so
    // software that reads a running count must allow for a carry between.

    function automatic logic wr_hit(input logic [4:0] o);
        wr_hit = wr_io && (off == o);
    endfunction

    // Keep the masked bits of a written byte
    function automatic logic [7:0] keep_bits(input logic [7:0] v, input logic [7:0] m);
        keep_bits = v & m;
    endfunction

    // High or low byte of a 16-bit view
    function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
        pick_byte = hi ? w[15:8] : w[7:0];
    endfunction

    // Sticky flag: an event wins over a clear in the same cycle
    function automatic logic flag_next(input logic cur, input logic set, input logic clr);
        flag_next = set || (cur && !clr);
    endfunction

    // Port data latches; a read of these slots returns the pins instead
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl.pa_out <= iomd_pkg::RESET_BYTE;
            ctrl.pb_out <= iomd_pkg::RESET_BYTE;
        end
        else
        begin
            if (wr_hit(iomd_pkg::OFF_PA_PINS))
                ctrl.pa_out <= keep_bits(req.wdata, iomd_pkg::PA_MASK);
            if (wr_hit(iomd_pkg::OFF_PB_PINS))
                ctrl.pb_out <= req.wdata;
        end
    end

    // Port A and B direction registers, read back as written except port A bits 7:6, which read zero
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl.pa_dir <= iomd_pkg::RESET_BYTE;
            ctrl.pb_dir <= iomd_pkg::RESET_BYTE;
        end
        else
        begin
            if (wr_hit(iomd_pkg::OFF_PA_DIR))
                ctrl.pa_dir <= keep_bits(req.wdata, iomd_pkg::PA_MASK);
            if (wr_hit(iomd_pkg::OFF_PB_DIR))
                ctrl.pb_dir <= req.wdata;
        end
    end

    // Port C latches; on the small package they stay zero, so software
    // probing for port C reads back nothing it could mistake for pins
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl.pc_out <= iomd_pkg::RESET_BYTE;
            ctrl.pc_dir <= iomd_pkg::RESET_BYTE;
        end
        else
        begin
            if (wr_hit(iomd_pkg::OFF_PC_PINS))
                ctrl.pc_out <= keep_bits(req.wdata, pc_mask);
            if (wr_hit(iomd_pkg::OFF_PC_DIR))
                ctrl.pc_dir <= keep_bits(req.wdata, pc_mask);
        end
    end

    // Write-only pulldown inhibits; they reach the pads but never the bus
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl.pac_pdi <= iomd_pkg::RESET_BYTE;
            ctrl.pb_pdi <= iomd_pkg::RESET_BYTE;
        end
        else
        begin
            // Port C inhibit bits 7:6 kept only when port C exists
            if (wr_hit(iomd_pkg::OFF_PAC_PDI))
                ctrl.pac_pdi <= keep_bits(req.wdata, iomd_pkg::PA_MASK | pc_mask);
            if (wr_hit(iomd_pkg::OFF_PB_PDI))
                ctrl.pb_pdi <= req.wdata;
        end
    end

    // Analog input select, all eight bits read/write
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ctrl.analog_input_select <= iomd_pkg::RESET_BYTE;
        else
        begin
            if (wr_hit(iomd_pkg::OFF_ANALOG_INPUT_SELECT))
                ctrl.analog_input_select <= req.wdata;
        end
    end

    // Tick timer control and sticky flags; an event beats a same-cycle clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl.tick_cs <= iomd_pkg::RESET_BYTE;
        end
        else
        begin
            if (tick_wr)
                ctrl.tick_cs[5:0] <= req.wdata[5:0] & iomd_pkg::TICK_RW_MASK[5:0];
            // Strobe bits 3 and 2 are never stored, so they always read zero
            ctrl.tick_cs[iomd_pkg::TICK_OVF_BIT] <= flag_next(
                ctrl.tick_cs[iomd_pkg::TICK_OVF_BIT], tick_ovf_event, tick_ovf_clr);
            ctrl.tick_cs[iomd_pkg::TICK_PER_BIT] <= flag_next(
                ctrl.tick_cs[iomd_pkg::TICK_PER_BIT], tick_per_event, tick_per_clr);
        end
    end

    // External interrupt control and sticky flag
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl.ext_cs <= iomd_pkg::RESET_BYTE;
        end
        else
        begin
            if (ext_wr)
                ctrl.ext_cs[7:5] <= req.wdata[7:5];
            // An edge arriving with the clear must not be lost
            ctrl.ext_cs[iomd_pkg::EXT_FLAG_BIT] <= flag_next(
                ctrl.ext_cs[iomd_pkg::EXT_FLAG_BIT], ext_irq_event, ext_clr);
        end
    end

    // Output compare value
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ctrl.compare <= 16'h0000;
        else
        begin
            if (wr_hit(iomd_pkg::OFF_CMP_HI))
                ctrl.compare[15:8] <= req.wdata;
            if (wr_hit(iomd_pkg::OFF_CMP_LO))
                ctrl.compare[7:0] <= req.wdata;
        end
    end

    // Read mux; write-only and unused slots read zero
    always_comb
    begin
        next_rdata = iomd_pkg::RESET_BYTE;
        unique case (off)
            iomd_pkg::OFF_PA_PINS: next_rdata = pa_pin_in & iomd_pkg::PA_MASK;
            iomd_pkg::OFF_PB_PINS: next_rdata = pb_pin_in;
            iomd_pkg::OFF_PC_PINS: next_rdata = pc_pin_in & pc_mask;
            iomd_pkg::OFF_ANALOG_INPUT_SELECT: next_rdata = ctrl.analog_input_select;
            iomd_pkg::OFF_PA_DIR: next_rdata = ctrl.pa_dir;
            iomd_pkg::OFF_PB_DIR: next_rdata = ctrl.pb_dir;
            iomd_pkg::OFF_PC_DIR: next_rdata = ctrl.pc_dir;
            iomd_pkg::OFF_TICK_CS: next_rdata = ctrl.tick_cs;
            iomd_pkg::OFF_TICK_CNT: next_rdata = tick_count;
            iomd_pkg::OFF_SER_CTRL: next_rdata = ser_ctrl_in;
            iomd_pkg::OFF_SER_FLAGS: next_rdata = ser_flags_in;
            iomd_pkg::OFF_SER_DATA: next_rdata = ser_data_in;
            iomd_pkg::OFF_EXT_CS: next_rdata = ctrl.ext_cs;
            iomd_pkg::OFF_CAP_CTRL: next_rdata = cap_ctrl_in;
            iomd_pkg::OFF_CAP_FLAGS: next_rdata = cap_flags_in;
            iomd_pkg::OFF_CAP_HI: next_rdata = pick_byte(capture_value, 1'b1);
            iomd_pkg::OFF_CAP_LO: next_rdata = pick_byte(capture_value, 1'b0);
            iomd_pkg::OFF_CMP_HI: next_rdata = ctrl.compare[15:8];
            iomd_pkg::OFF_CMP_LO: next_rdata = ctrl.compare[7:0];
            iomd_pkg::OFF_CNT_HI: next_rdata = pick_byte(free_count, 1'b1);
            iomd_pkg::OFF_CNT_LO: next_rdata = pick_byte(free_count, 1'b0);
            iomd_pkg::OFF_ALT_HI: next_rdata = pick_byte(free_count, 1'b1);
            iomd_pkg::OFF_ALT_LO: next_rdata = pick_byte(free_count, 1'b0);
            iomd_pkg::OFF_ANA_CTRL: next_rdata = ana_ctrl_in;
            iomd_pkg::OFF_ANA_FLAGS: next_rdata = ana_flags_in;
            default: next_rdata = iomd_pkg::RESET_BYTE;
        endcase
    end

    // Read answer flag, one cycle after any read request
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rvalid <= 1'b0;
        else
            rvalid <= req.valid && !req.write;
    end

    // Registered read data, one cycle after the request
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata <= iomd_pkg::RESET_BYTE;
        else
        begin
            // Outside the I/O block the byte is the memory's, so answer zero here
            rdata <= (in_io && !req.write) ? next_rdata : iomd_pkg::RESET_BYTE;
        end
    end

    // Write pass-through for peripherals that own their registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            periph_wr <= 1'b0;
            periph_wr_off <= 5'h00;
            periph_wr_data <= iomd_pkg::RESET_BYTE;
        end
        else
        begin
            periph_wr <= wr_io;
            periph_wr_off <= off;
            periph_wr_data <= req.wdata;
        end
    end

    // Watchdog service pulse; a read of the slot does not service it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            watchdog_service <= 1'b0;
        else
            watchdog_service <= hit_wd && req.write;
    end
endmodule

// File: iomd_pkg.sv
// Shared constants and types for the I/O register map decoder
package iomd_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam logic [12:0] IO_LIMIT = 13'h0020;
    localparam logic [12:0] WATCHDOG_ADDR = 13'h1ff0;
    // Register offsets
    localparam logic [4:0] OFF_PA_PINS = 5'h00;
    localparam logic [4:0] OFF_PB_PINS = 5'h01;
    localparam logic [4:0] OFF_PC_PINS = 5'h02;
    localparam logic [4:0] OFF_ANALOG_INPUT_SELECT = 5'h03;
    localparam logic [4:0] OFF_PA_DIR = 5'h04;
    localparam logic [4:0] OFF_PB_DIR = 5'h05;
    localparam logic [4:0] OFF_PC_DIR = 5'h06;
    localparam logic [4:0] OFF_TICK_CS = 5'h08;
    localparam logic [4:0] OFF_TICK_CNT = 5'h09;
    localparam logic [4:0] OFF_SER_CTRL = 5'h0a;
    localparam logic [4:0] OFF_SER_FLAGS = 5'h0b;
    localparam logic [4:0] OFF_SER_DATA = 5'h0c;
    localparam logic [4:0] OFF_EXT_CS = 5'h0d;
    localparam logic [4:0] OFF_PAC_PDI = 5'h10;
    localparam logic [4:0] OFF_PB_PDI = 5'h11;
    localparam logic [4:0] OFF_CAP_CTRL = 5'h12;
    localparam logic [4:0] OFF_CAP_FLAGS = 5'h13;
    localparam logic [4:0] OFF_CAP_HI = 5'h14;
    localparam logic [4:0] OFF_CAP_LO = 5'h15;
    localparam logic [4:0] OFF_CMP_HI = 5'h16;
    localparam logic [4:0] OFF_CMP_LO = 5'h17;
    localparam logic [4:0] OFF_CNT_HI = 5'h18;
    localparam logic [4:0] OFF_CNT_LO = 5'h19;
    localparam logic [4:0] OFF_ALT_HI = 5'h1a;
    localparam logic [4:0] OFF_ALT_LO = 5'h1b;
    localparam logic [4:0] OFF_ANA_CTRL = 5'h1d;
    localparam logic [4:0] OFF_ANA_FLAGS = 5'h1e;
    // Field masks
    localparam logic [7:0] PA_MASK = 8'h3f;
    localparam logic [7:0] TICK_RW_MASK = 8'h33;
    localparam logic [7:0] TICK_FLAG_MASK = 8'hc0;
    localparam int TICK_OVF_BIT = 7;
    localparam int TICK_PER_BIT = 6;
    localparam int TICK_OVF_CLR_BIT = 3;
    localparam int TICK_PER_CLR_BIT = 2;
    localparam logic [7:0] EXT_RW_MASK = 8'he0;
    localparam int EXT_FLAG_BIT = 3;
    localparam int EXT_CLR_BIT = 1;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Processor bus request
    typedef struct packed {
        logic valid;
        logic write;
        logic [12:0] addr;
        logic [7:0] wdata;
    } iomd_req_t;
    // Peripheral controls presented to the outside
    typedef struct packed {
        logic [7:0] pa_dir;
        logic [7:0] pb_dir;
        logic [7:0] pc_dir;
        logic [7:0] pa_out;
        logic [7:0] pb_out;
        logic [7:0] pc_out;
        logic [7:0] pac_pdi;
        logic [7:0] pb_pdi;
        logic [7:0] analog_input_select;
        logic [7:0] tick_cs;
        logic [7:0] ext_cs;
        logic [15:0] compare;
    } iomd_ctrl_t;
endpackage

// File: iomd_decoder_checker.sv
// Bus timing and register-view assertions for the I/O decoder
`timescale 1ns/1ps
module iomd_decoder_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Processor bus
    input wire iomd_pkg::iomd_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    // Views and outputs
    input wire logic [15:0] capture_value,
    input wire logic [15:0] free_count,
    input wire iomd_pkg::iomd_ctrl_t ctrl,
    input wire logic periph_wr,
    input wire logic [4:0] periph_wr_off,
    input wire logic watchdog_service,
    input wire logic ext_irq_event
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Read answers come exactly one cycle after the request
    a_read_answer: assert property (req.valid && !req.write |=> rvalid)
        else $error("read not answered next cycle");
    a_stray_answer: assert property (!(req.valid && !req.write) |=> !rvalid)
        else $error("answer without a read");
    a_port_a_pins_upper: assert property (rvalid && $past(req.addr) == 13'h0000 |-> rdata[7:6] == 2'b00)
        else $error("port A upper bits not zero");
    a_dira_store: assert property (req.valid && req.write && req.addr == 13'h0004
        |=> ctrl.pa_dir == ($past(req.wdata) & 8'h3f))
        else $error("port A direction wrong");
    a_dirb_store: assert property (req.valid && req.write && req.addr == 13'h0005
        |=> ctrl.pb_dir == $past(req.wdata))
        else $error("port B direction wrong");
    a_pulldown_hidden: assert property (rvalid && $past(req.addr[12:1]) == 12'h008
        |-> rdata == 8'h00)
        else $error("write-only pulldown readable");
    a_tick_strobe: assert property (rvalid && $past(req.addr) == 13'h0008 |-> rdata[3:2] == 2'b00)
        else $error("tick strobes read nonzero");
    a_ext_zero: assert property (rvalid && $past(req.addr) == 13'h000d |-> (rdata & 8'h17) == 8'h00)
        else $error("external control zero bits set");
    a_capture_view: assert property (rvalid && $past(req.addr) == 13'h0014
        |-> rdata == $past(capture_value[15:8]))
        else $error("capture high byte wrong");
    a_alt_low: assert property (rvalid && $past(req.addr) == 13'h001b
        |-> rdata == $past(free_count[7:0]))
        else $error("alternate count low byte wrong");
    a_outside_zero: assert property (rvalid && $past(req.addr) >= 13'h0020 |-> rdata == 8'h00)
        else $error("outside address read nonzero");
    a_io_write_strobe: assert property (req.valid && req.write && req.addr < 13'h0020
        |=> periph_wr && periph_wr_off == $past(req.addr[4:0]))
        else $error("peripheral write strobe wrong");
    a_wdog_cause: assert property (watchdog_service
        |-> $past(req.valid && req.write && req.addr == 13'h1ff0))
        else $error("watchdog pulse without its write");
    a_event_wins: assert property (ext_irq_event |=> ctrl.ext_cs[3])
        else $error("flag event lost to a clear");
    // Main scenarios reached
    c_read: cover property (rvalid);
    c_wdog: cover property (watchdog_service);
    c_tick_clear: cover property (req.valid && req.write && req.addr == 13'h0008 && req.wdata[3]);
endmodule

bind iomd_decoder iomd_decoder_checker iomd_decoder_checker_inst (.clk(clk), .reset_n(reset_n),
    .req(req), .rdata(rdata), .rvalid(rvalid), .capture_value(capture_value),
    .free_count(free_count), .ctrl(ctrl), .periph_wr(periph_wr),
    .periph_wr_off(periph_wr_off), .watchdog_service(watchdog_service),
    .ext_irq_event(ext_irq_event));

// File: iomd_cpu_model.sv
// Processor core bus model issuing single-byte memory cycles
`timescale 1ns/1ps
module iomd_cpu_model (
    // Clock
    input wire logic clk,
    // Bus to decoder
    output iomd_pkg::iomd_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    // Idle bus until the first cycle
    initial req = '0;
    // Plain memory read on a 13-bit address, no I/O cycle type
    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{valid: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '{valid: 1'b0, write: 1'b0, addr: ~a, wdata: 8'h00};
        #1;
        // A missing answer yields unknown so the compare fails
        d = (rvalid === 1'b1) ? rdata : 8'hxx;
    endtask
    // Plain memory write, effective at the taking edge
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        @(posedge clk);
        req <= '{valid: 1'b1, write: 1'b1, addr: a, wdata: v};
        @(posedge clk);
        req <= '{valid: 1'b0, write: 1'b0, addr: ~a, wdata: ~v};
        #1;
    endtask
endmodule

// File: iomd_decoder_bench.sv
// Self-checking bench for the I/O register decoder
`timescale 1ns/1ps
module iomd_decoder_bench;
    logic clk;
    logic reset_n;
    iomd_pkg::iomd_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] pin [3];
    logic [7:0] view [8];
    logic [2:0] ev;
    iomd_pkg::iomd_ctrl_t ctrl;
    logic periph_wr;
    logic [4:0] periph_wr_off;
    logic wdog;
    logic [7:0] got;
    int err_count;
    int tests_run;
    int cycles;
    // Tables of read/write places, masks, peripheral views and holes
    localparam logic [12:0] RW_A [6] = '{13'h03, 13'h04, 13'h05, 13'h06, 13'h16, 13'h17};
    localparam logic [7:0] RW_M [6] = '{8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff};
    localparam logic [12:0] VW_A [8] = '{13'h09, 13'h0a, 13'h0b, 13'h0c, 13'h12, 13'h13, 13'h1d, 13'h1e};
    localparam logic [12:0] HOLE [7] = '{13'h07, 13'h0e, 13'h0f, 13'h1c, 13'h1f, 13'h20, 13'h1ff1};
    iomd_cpu_model cpu_inst (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    iomd_decoder iomd_decoder_inst (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
        .rvalid(rvalid), .pa_pin_in(pin[0]), .pb_pin_in(pin[1]), .pc_pin_in(pin[2]),
        .tick_ovf_event(ev[0]), .tick_per_event(ev[1]), .ext_irq_event(ev[2]),
        .tick_count(view[0]), .ser_ctrl_in(view[1]), .ser_flags_in(view[2]),
        .ser_data_in(view[3]), .cap_ctrl_in(view[4]), .cap_flags_in(view[5]),
        .capture_value(16'hc3a5), .free_count(16'h1e2d), .ana_ctrl_in(view[6]),
        .ana_flags_in(view[7]), .ctrl(ctrl), .periph_wr(periph_wr),
        .periph_wr_off(periph_wr_off), .periph_wr_data(), .watchdog_service(wdog));
    // Clock at 100 MHz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        cpu_inst.rd(a, got);
        chk($sformatf("read %h", a), exp, got);
    endtask
    // One-cycle flag event pulse
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 3'b000;
    endtask
    task automatic finish_test;
        $display("Checks %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Cut a hang short; the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            finish_test();
        end
    end
    initial
    begin
        err_count = 0;
        tests_run = 0;
        cycles = 0;
        reset_n = 1'b0;
        ev = 3'b000;
        pin = '{8'hff, 8'h96, 8'h69};
        view = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(13'h0005, 8'h00);
        rd_chk(13'h0000, 8'h3f);
        rd_chk(13'h0001, 8'h96);
        rd_chk(13'h0002, 8'h69);
        // Read/write places with two patterns each
        for (int i = 0; i < 6; i++)
        begin
            cpu_inst.wr(RW_A[i], 8'hff);
            rd_chk(RW_A[i], RW_M[i]);
            cpu_inst.wr(RW_A[i], 8'h5a);
            rd_chk(RW_A[i], 8'h5a & RW_M[i]);
        end
        chk("io write offset", 8'h17, {3'b000, periph_wr_off});
        for (int i = 0; i < 8; i++)
            rd_chk(VW_A[i], view[i]);
        // Read-only views ignore writes
        cpu_inst.wr(13'h0014, 8'h00);
        cpu_inst.wr(13'h0019, 8'h00);
        rd_chk(13'h0014, 8'hc3);
        rd_chk(13'h0015, 8'ha5);
        rd_chk(13'h0018, 8'h1e);
        rd_chk(13'h0019, 8'h2d);
        rd_chk(13'h001a, 8'h1e);
        rd_chk(13'h001b, 8'h2d);
        for (int i = 0; i < 7; i++)
        begin
            cpu_inst.wr(HOLE[i], 8'hff);
            rd_chk(HOLE[i], 8'h00);
        end
        // Write-only pulldown inhibits
        cpu_inst.wr(13'h0010, 8'hc5);
        rd_chk(13'h0010, 8'h00);
        chk("pac_pdi", 8'hc5, ctrl.pac_pdi);
        cpu_inst.wr(13'h0011, 8'h3c);
        rd_chk(13'h0011, 8'h00);
        chk("pb_pdi", 8'h3c, ctrl.pb_pdi);
        // Tick timer flags, zero-write leaves them, each strobe clears one
        cpu_inst.wr(13'h0008, 8'hff);
        rd_chk(13'h0008, 8'h33);
        pulse(3'b011);
        rd_chk(13'h0008, 8'hf3);
        cpu_inst.wr(13'h0008, 8'h33);
        rd_chk(13'h0008, 8'hf3);
        cpu_inst.wr(13'h0008, 8'h3b);
        rd_chk(13'h0008, 8'h73);
        cpu_inst.wr(13'h0008, 8'h37);
        rd_chk(13'h0008, 8'h33);
        // External interrupt control and flag
        cpu_inst.wr(13'h000d, 8'hff);
        rd_chk(13'h000d, 8'he0);
        pulse(3'b100);
        rd_chk(13'h000d, 8'he8);
        cpu_inst.wr(13'h000d, 8'he0);
        rd_chk(13'h000d, 8'he8);
        cpu_inst.wr(13'h000d, 8'he2);
        rd_chk(13'h000d, 8'he0);
        // Event and clear taken at one edge: the event wins
        fork
            pulse(3'b100);
            cpu_inst.wr(13'h000d, 8'he2);
        join
        rd_chk(13'h000d, 8'he8);
        // Port A data latch keeps only six bits
        cpu_inst.wr(13'h0000, 8'hff);
        chk("pa_out", 8'h3f, ctrl.pa_out);
        // Watchdog service location at the top of the space
        cpu_inst.wr(13'h1ff0, 8'h00);
        chk("watchdog pulse", 8'h01, {7'h00, wdog});
        chk("no io strobe", 8'h00, {7'h00, periph_wr});
        @(posedge clk);
        #1;
        chk("watchdog idle", 8'h00, {7'h00, wdog});
        finish_test();
    end
endmodule
